// ==== logic/pawt_pkg.sv ====
package pawt_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } pawt_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pawt_wb_rsp_t;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } pawt_addr_req_t;

    typedef struct packed {
        logic        fwd;
        logic        io;
        logic        miss;
        logic [31:0] addr;
    } pawt_mst_rsp_t;

    typedef struct packed {
        logic        claim;
        logic        win2;
        logic        miss;
        logic [31:0] addr;
    } pawt_tgt_rsp_t;

    typedef struct packed {
        logic [4:0][31:0] win;
        pawt_wb_rsp_t     wb;
        pawt_mst_rsp_t    mst;
        pawt_tgt_rsp_t    tgt;
    } pawt_state_t;

endpackage

// ==== logic/pawt_regs.svh ====
`ifndef PAWT_REGS_SVH
`define PAWT_REGS_SVH

// register block base; address bits 4:2 select the register, bits 1:0 must be zero
`define PAWT_BASE_ADDR       32'h0F000C00
`define PAWT_OFS_MWIN1       32'h0F000C00
`define PAWT_OFS_MWIN2       32'h0F000C04
`define PAWT_OFS_TWIN1       32'h0F000C08
`define PAWT_OFS_TWIN2       32'h0F000C0C
`define PAWT_OFS_MIOWIN      32'h0F000C10

// register slots in the window array
`define PAWT_IDX_MWIN1       3'h0
`define PAWT_IDX_MWIN2       3'h1
`define PAWT_IDX_TWIN1       3'h2
`define PAWT_IDX_TWIN2       3'h3
`define PAWT_IDX_MIOWIN      3'h4

// field positions
`define PAWT_IBA_MSB         31
`define PAWT_IBA_LSB         24
`define PAWT_MSK_MSB         19
`define PAWT_MSK_LSB         13
`define PAWT_EN_BIT          12
`define PAWT_PCIA_MSB        7
`define PAWT_PCIA_LSB        0
`define PAWT_ITA_MSB         10
`define PAWT_ITA_LSB         0

// reset values
`define PAWT_RST_MWIN        32'h100F0000
`define PAWT_RST_TWIN        32'h00000000

// writable bits; reserved bits stay zero
`define PAWT_WMASK_MWIN      32'hFF0FF0FF
`define PAWT_WMASK_TWIN      32'h000FF7FF

`endif

// ==== logic/pawt_top.sv ====
// Overview of operation
// - master window hits when address bits 31:24 equal base, masked bits ignored
// - seven master mask bits cover address bits 30:24; one keeps, zero masks
// - master masking yields window sizes from 16 MB up to 2 GB
// - bit 12 of each window register enables that window
// - master memory hit swaps unmasked upper bits for PCI upper address field
// - reserved window register bits read zero and ignore writes
// - seven target mask bits cover PCI address bits 27:21; one keeps, zero masks
// - target masking yields window sizes from 2 MB up to 256 MB
// - target window hits when PCI bits 31:21 equal its configured memory base
// - target hit swaps unmasked upper bits for the 11-bit internal address field
// - I/O window hit swaps unmasked upper bits for I/O upper field, I/O space
//
// Our own choice: the Wishbone slave port.
`include "pawt_regs.svh"

module pawt_top (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire pawt_pkg::pawt_wb_req_t  wb_i,
    output pawt_pkg::pawt_wb_rsp_t       wb_o,
    input  wire pawt_pkg::pawt_addr_req_t cpu_i,
    output pawt_pkg::pawt_mst_rsp_t      pci_o,
    input  wire pawt_pkg::pawt_addr_req_t pci_i,
    input  wire logic [10:0]             pci_membase_first_i,
    input  wire logic [10:0]             pci_membase_second_i,
    output pawt_pkg::pawt_tgt_rsp_t      int_o
);
    import pawt_pkg::*;

    pawt_state_t st;
    pawt_state_t next_st;

    // compare mask for a master window: bit 31 always compared
    function automatic logic [7:0] mst_keep(input logic [31:0] w);
        mst_keep = {1'b1, w[`PAWT_MSK_MSB:`PAWT_MSK_LSB]};
    endfunction

    // compare mask for a target window: bits 31:28 always compared
    function automatic logic [10:0] tgt_keep(input logic [31:0] w);
        tgt_keep = {4'hF, w[`PAWT_MSK_MSB:`PAWT_MSK_LSB]};
    endfunction

    // byte-lane merge restricted to the writable bits of a register
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel,
        input logic [31:0] wmask
    );
        logic [31:0] lanes;
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        lanes = lanes & wmask;
        lane_merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
    endfunction

    function automatic logic [31:0] slot_wmask(input logic [2:0] idx);
        if (idx == `PAWT_IDX_TWIN1 || idx == `PAWT_IDX_TWIN2)
        begin
            slot_wmask = `PAWT_WMASK_TWIN;
        end
        else
        begin
            slot_wmask = `PAWT_WMASK_MWIN;
        end
    endfunction

    // register decode
    logic       reg_hit;
    logic [2:0] reg_idx;
    logic       bus_req;

    assign bus_req = wb_i.cyc && wb_i.stb && !st.wb.ack;
    assign reg_idx = wb_i.adr[4:2];
    assign reg_hit = (wb_i.adr[31:5] == 27'(`PAWT_BASE_ADDR >> 5))
                     && (wb_i.adr[1:0] == 2'h0)
                     && (reg_idx <= `PAWT_IDX_MIOWIN);

    // master windows: slot 0 = memory 1, slot 1 = memory 2, slot 2 = I/O
    logic [2:0]       m_hit;
    logic [2:0][31:0] m_addr;

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_mst
            localparam logic [2:0] SLOT = (g == 2) ? `PAWT_IDX_MIOWIN : 3'(g);
            logic [31:0] w;
            logic [7:0]  keep;
            assign w    = st.win[SLOT];
            assign keep = mst_keep(w);
            // masked bits take part in neither the compare nor the swap
            assign m_hit[g] = w[`PAWT_EN_BIT]
                && (((cpu_i.addr[31:24] ^ w[`PAWT_IBA_MSB:`PAWT_IBA_LSB]) & keep)
                    == 8'h00);
            assign m_addr[g] = {(w[`PAWT_PCIA_MSB:`PAWT_PCIA_LSB] & keep)
                                | (cpu_i.addr[31:24] & ~keep),
                                cpu_i.addr[23:0]};
        end
    endgenerate

    // target windows: slot 0 = window 1, slot 1 = window 2
    logic [1:0]       t_hit;
    logic [1:0][31:0] t_addr;
    logic [1:0][10:0] t_base;

    assign t_base[0] = pci_membase_first_i;
    assign t_base[1] = pci_membase_second_i;

    generate
        for (g = 0; g < 2; g++)
        begin : g_tgt
            logic [31:0] w;
            logic [10:0] keep;
            assign w    = st.win[`PAWT_IDX_TWIN1 + 3'(g)];
            assign keep = tgt_keep(w);
            assign t_hit[g] = w[`PAWT_EN_BIT]
                && (((pci_i.addr[31:21] ^ t_base[g]) & keep) == 11'h000);
            assign t_addr[g] = {(w[`PAWT_ITA_MSB:`PAWT_ITA_LSB] & keep)
                                | (pci_i.addr[31:21] & ~keep),
                                pci_i.addr[20:0]};
        end
    endgenerate

    always_comb
    begin
        next_st = st;

        // register bus: one-cycle answer, ack drops the cycle after
        next_st.wb.ack = 1'b0;
        next_st.wb.dat = 32'h00000000;
        if (bus_req)
        begin
            next_st.wb.ack = 1'b1;
            // unmapped addresses are acknowledged, read zero, drop writes
            if (reg_hit)
            begin
                if (wb_i.we)
                begin
                    next_st.win[reg_idx] = lane_merge(st.win[reg_idx], wb_i.dat,
                                                      wb_i.sel, slot_wmask(reg_idx));
                end
                else
                begin
                    next_st.wb.dat = st.win[reg_idx];
                end
            end
        end

        // master translation, one cycle after the request
        next_st.mst.fwd  = 1'b0;
        next_st.mst.io   = 1'b0;
        next_st.mst.miss = 1'b0;
        next_st.mst.addr = 32'h00000000;
        if (cpu_i.req)
        begin
            if (m_hit[0])
            begin
                next_st.mst.fwd  = 1'b1;
                next_st.mst.addr = m_addr[0];
            end
            else if (m_hit[1])
            begin
                next_st.mst.fwd  = 1'b1;
                next_st.mst.addr = m_addr[1];
            end
            else if (m_hit[2])
            begin
                next_st.mst.fwd  = 1'b1;
                next_st.mst.io   = 1'b1;
                next_st.mst.addr = m_addr[2];
            end
            else
            begin
                next_st.mst.miss = 1'b1;
            end
        end

        // target translation, one cycle after the request
        next_st.tgt.claim = 1'b0;
        next_st.tgt.win2  = 1'b0;
        next_st.tgt.miss  = 1'b0;
        next_st.tgt.addr  = 32'h00000000;
        if (pci_i.req)
        begin
            // window 1 wins an overlap so the outcome stays deterministic
            if (t_hit[0])
            begin
                next_st.tgt.claim = 1'b1;
                next_st.tgt.addr  = t_addr[0];
            end
            else if (t_hit[1])
            begin
                next_st.tgt.claim = 1'b1;
                next_st.tgt.win2  = 1'b1;
                next_st.tgt.addr  = t_addr[1];
            end
            else
            begin
                next_st.tgt.miss = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st.win[`PAWT_IDX_MWIN1]  <= `PAWT_RST_MWIN;
            st.win[`PAWT_IDX_MWIN2]  <= `PAWT_RST_MWIN;
            st.win[`PAWT_IDX_TWIN1]  <= `PAWT_RST_TWIN;
            st.win[`PAWT_IDX_TWIN2]  <= `PAWT_RST_TWIN;
            st.win[`PAWT_IDX_MIOWIN] <= `PAWT_RST_MWIN;
            st.wb  <= '0;
            st.mst <= '0;
            st.tgt <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wb_o  = st.wb;
    assign pci_o = st.mst;
    assign int_o = st.tgt;

endmodule // pawt_top

// ==== sim/pawt_cfg_model.sv ====
module pawt_cfg_model (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    output logic [10:0] first_o,
    output logic [10:0] second_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // config software sets the bases once; kept clear of the master pci ranges
    always_ff @(posedge clk_i)
    begin
        first_o  <= rst_i ? 11'h000 : 11'h101;
        second_o <= rst_i ? 11'h000 : 11'h300;
    end
endmodule // pawt_cfg_model

// ==== sim/pawt_top_properties.sv ====
module pawt_top_properties (
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire pawt_pkg::pawt_wb_req_t   wb_i,
    input wire pawt_pkg::pawt_wb_rsp_t   wb_o,
    input wire pawt_pkg::pawt_addr_req_t cpu_i,
    input wire pawt_pkg::pawt_mst_rsp_t  pci_o,
    input wire pawt_pkg::pawt_addr_req_t pci_i,
    input wire pawt_pkg::pawt_tgt_rsp_t  int_o
);
    import pawt_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken;
        wb_i.cyc && wb_i.stb && !wb_o.ack;
    endsequence
    a_ack_follows: assert property (s_taken |=> wb_o.ack ##1 !wb_o.ack)
        else $error("ack not a single cycle after request");
    a_dat_idle_zero: assert property (!wb_o.ack |-> wb_o.dat == 32'h00000000)
        else $error("read data not zero outside ack");
    a_fwd_xor_miss: assert property (cpu_i.req |=> pci_o.fwd ^ pci_o.miss)
        else $error("cpu request without exactly one result");
    a_mst_quiet: assert property (!cpu_i.req |=> !pci_o.fwd && !pci_o.miss)
        else $error("master result without request");
    a_mst_low_pass: assert property (cpu_i.req |=> !pci_o.fwd
        || pci_o.addr[23:0] == $past(cpu_i.addr[23:0]))
        else $error("low address bits changed");
    a_mst_idle_addr: assert property (!pci_o.fwd |-> pci_o.addr == 32'h00000000 && !pci_o.io)
        else $error("pci address not zero without forward");
    a_claim_xor_miss: assert property (pci_i.req |=> int_o.claim ^ int_o.miss)
        else $error("pci request without exactly one result");
    a_tgt_low_pass: assert property (pci_i.req |=> !int_o.claim
        || int_o.addr[20:0] == $past(pci_i.addr[20:0]))
        else $error("low target bits changed");
    a_tgt_idle_addr: assert property (!int_o.claim |-> int_o.addr == 32'h00000000)
        else $error("internal address not zero without claim");
endmodule // pawt_top_properties

// ==== sim/pawt_top_tb.sv ====
`include "pawt_regs.svh"
module pawt_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pawt_pkg::*;
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    pawt_wb_req_t   wb_i = '0;
    pawt_wb_rsp_t   wb_o;
    pawt_addr_req_t cpu_i = '0;
    pawt_addr_req_t pci_i = '0;
    pawt_mst_rsp_t  pci_o;
    pawt_tgt_rsp_t  int_o;
    logic [10:0]    mb1;
    logic [10:0]    mb2;
    logic [31:0]    rd;
    int             err_total = 0;
    int             n_tests = 0;
    always #20 clk_i = ~clk_i;
    pawt_cfg_model i_pawt_cfg_model (.clk_i(clk_i), .rst_i(rst_i), .first_o(mb1), .second_o(mb2));
    pawt_top i_pawt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .cpu_i(cpu_i),
        .pci_o(pci_o), .pci_i(pci_i), .pci_membase_first_i(mb1),
        .pci_membase_second_i(mb2), .int_o(int_o));
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wbx(input logic we, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_i <= '{1'b1, 1'b1, we, 4'hF, a, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_o.ack !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            final_report;
        end
        rd = wb_o.dat;
        wb_i <= '0;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h00000000);
        chk({4'h0, rd}, {4'h0, e});
    endtask
    task automatic xm(input logic [31:0] a, input logic [2:0] f, input logic [31:0] e);
        @(posedge clk_i);
        cpu_i <= '{1'b1, a};
        @(posedge clk_i);
        cpu_i <= '0;
        @(negedge clk_i);
        chk({1'b0, pci_o}, {1'b0, f, e});
    endtask
    task automatic xt(input logic [31:0] a, input logic [2:0] f, input logic [31:0] e);
        @(posedge clk_i);
        pci_i <= '{1'b1, a};
        @(posedge clk_i);
        pci_i <= '0;
        @(negedge clk_i);
        chk({1'b0, int_o}, {1'b0, f, e});
    endtask
    task automatic final_report;
        $display("mismatches %0d of %0d checks", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`PAWT_OFS_MWIN1, 32'h100F0000);
        rdc(`PAWT_OFS_MWIN2, 32'h100F0000);
        rdc(`PAWT_OFS_TWIN1, 32'h00000000);
        rdc(`PAWT_OFS_TWIN2, 32'h00000000);
        rdc(`PAWT_OFS_MIOWIN, 32'h100F0000);
        xm(32'h10000000, 3'b001, 32'h00000000);
        wbx(1'b1, `PAWT_OFS_MWIN1, 32'h200FF080);
        rdc(`PAWT_OFS_MWIN1, 32'h200FF080);
        wbx(1'b1, `PAWT_OFS_MWIN2, 32'h400010C0);
        wbx(1'b1, `PAWT_OFS_MIOWIN, 32'h900FF033);
        xm(32'h20123456, 3'b100, 32'h80123456);
        xm(32'hA1000000, 3'b001, 32'h00000000);
        xm(32'h7F000000, 3'b100, 32'hFF000000);
        xm(32'h20000010, 3'b100, 32'h80000010);
        xm(32'h90000004, 3'b110, 32'h33000004);
        wbx(1'b1, `PAWT_OFS_TWIN1, 32'h000FF055);
        wbx(1'b1, `PAWT_OFS_TWIN2, 32'h000017FF);
        xt(32'h20212345, 3'b100, 32'h0AA12345);
        xt(32'h6FE00001, 3'b110, 32'hFFE00001);
        xt(32'h40000000, 3'b001, 32'h00000000);
        wbx(1'b1, 32'h0F000C14, 32'h00001234);
        rdc(32'h0F000C14, 32'h00000000);
        final_report;
    end
    initial
    begin
        #400000;
        err_total++;
        final_report;
    end
endmodule // pawt_top_tb
bind pawt_top pawt_top_properties i_pawt_top_properties (.clk_i(clk_i), .rst_i(rst_i),
    .wb_i(wb_i), .wb_o(wb_o), .cpu_i(cpu_i), .pci_o(pci_o), .pci_i(pci_i), .int_o(int_o));
